// file: hw/tpc_pkg.sv
// Shared types and constants for the timer channel capture/compare/PWM block
package tpc_pkg;

  // ==========================================================
  // Counter and value constants
  localparam logic [15:0] TPC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TPC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TPC_CNT_STEP = 16'h0001;
  localparam int TPC_SIGN_BIT = 15;

  // ==========================================================
  // Channel modes while center-aligned select is off
  typedef enum logic [1:0] {
    TPC_MODE_CAPTURE = 2'b00,
    TPC_MODE_COMPARE = 2'b01,
    TPC_MODE_EPWM = 2'b10
  } tpc_mode_t;

  // Capture edge select codes
  localparam logic [1:0] TPC_EDGE_OFF = 2'h0;
  localparam logic [1:0] TPC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TPC_EDGE_ANY = 2'h3;

  // Compare pin actions
  localparam logic [1:0] TPC_ACT_NONE = 2'h0;
  localparam logic [1:0] TPC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TPC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TPC_ACT_SET = 2'h3;

  // Bit of the edge/level field that is the PWM polarity bit
  localparam int TPC_POL_BIT = 0;

  // ==========================================================
  // Per-channel configuration, a snapshot of channel_control
  typedef struct packed {
    logic irq_enable;
    tpc_mode_t mode;
    logic [1:0] edge_level;
  } tpc_ch_cfg_t;

  // Byte access from the CPU side
  typedef struct packed {
    logic high;
    logic [7:0] data;
  } tpc_byte_t;

endpackage

// file: hw/tpc_flag.sv
// Event flag with the two-step read-then-write-zero clear
`timescale 1ns/1ps
`default_nettype none
module tpc_flag (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic set_in,
  input wire logic rd_in,
  input wire logic clr_in,
  output logic flag_out
);
  import tpc_pkg::*;

  logic armed_reg;

  // ==========================================================
  // Clear arming: a read while set arms, any new event disarms
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed_reg <= 1'b0;
    end else if (set_in) begin
      armed_reg <= 1'b0;
    end else if (rd_in && flag_out) begin
      armed_reg <= 1'b1;
    end else if (clr_in) begin
      armed_reg <= 1'b0;
    end
  end

  // Flag itself; the event wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in && armed_reg) begin
      flag_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: hw/tpc_timer.sv
// Shared 16-bit counter, modulus and capture/compare/PWM channels
`timescale 1ns/1ps
`default_nettype none
module tpc_timer #(
  parameter int NCH = 2
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Timer counting clock, one-cycle enable
  input wire logic count_en_in,
  // Timer control and counter access
  input wire logic timer_control_wr_in,
  input wire logic center_align_select_in,
  input wire logic overflow_irq_enable_in,
  input wire logic main_counter_wr_in,
  input wire logic modulus_wr_in,
  input wire tpc_pkg::tpc_byte_t modulus_byte_in,
  output logic [15:0] main_counter_out,
  output logic [15:0] modulus_out,
  // Overflow flag
  input wire logic overflow_flag_rd_in,
  input wire logic overflow_flag_clr_in,
  output logic overflow_flag_out,
  output logic overflow_irq_out,
  // Channel control and value access
  input wire tpc_pkg::tpc_ch_cfg_t [NCH-1:0] channel_control_in,
  input wire logic [NCH-1:0] channel_control_wr_in,
  input wire logic [NCH-1:0] channel_value_wr_in,
  input wire logic [NCH-1:0] channel_value_rd_in,
  input wire tpc_pkg::tpc_byte_t channel_value_byte_in,
  output logic [NCH-1:0][7:0] channel_value_rdata_out,
  // Channel flags
  input wire logic [NCH-1:0] channel_flag_rd_in,
  input wire logic [NCH-1:0] channel_flag_clr_in,
  output logic [NCH-1:0] channel_flag_out,
  output logic [NCH-1:0] channel_irq_out,
  // Channel pins
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe_n_out
);
  import tpc_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (NCH < 1) begin : g_bad_nch
    $error("NCH must be at least one");
  end

  // ==========================================================
  // Counter state
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic dir_down_reg;
  logic dir_down_next;
  logic wrap_evt;
  logic turn_evt;
  logic step_up;

  // Modulus with its byte buffer
  logic [15:0] mod_reg;
  logic [15:0] mod_buf_reg;
  logic mod_got_high_reg;
  logic mod_got_low_reg;
  logic mod_pend_reg;
  logic mod_both;
  logic mod_commit;

  // Channel state
  logic [NCH-1:0][15:0] val_reg;
  logic [NCH-1:0][15:0] wbuf_reg;
  logic [NCH-1:0][15:0] rlatch_reg;
  logic [NCH-1:0] got_high_reg;
  logic [NCH-1:0] got_low_reg;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] rd_hold_reg;
  logic [NCH-1:0] rd_first_high_reg;
  logic [NCH-1:0] pin_meta_reg;
  logic [NCH-1:0] pin_sync_reg;
  logic [NCH-1:0] pin_prev_reg;
  logic [NCH-1:0] cap_evt;
  logic [NCH-1:0] match_evt;
  logic [NCH-1:0] commit;
  logic [NCH-1:0] both_bytes;
  logic [NCH-1:0] flag_set;
  logic [NCH-1:0] is_capture;
  logic [NCH-1:0] is_compare;
  logic [NCH-1:0] is_epwm;

  assign main_counter_out = cnt_reg;
  assign modulus_out = mod_reg;

  // ==========================================================
  // Next count; up/down mode turns at modulus and at zero
  always_comb begin
    cnt_next = cnt_reg;
    dir_down_next = 1'b0;
    wrap_evt = 1'b0;
    turn_evt = 1'b0;
    if (center_align_select_in) begin
      dir_down_next = dir_down_reg;
      if (count_en_in) begin
        if (!dir_down_reg && cnt_reg == mod_reg) begin
          cnt_next = cnt_reg - TPC_CNT_STEP;
          dir_down_next = 1'b1;
          turn_evt = 1'b1;
        end else if (dir_down_reg && cnt_reg == TPC_CNT_ZERO) begin
          cnt_next = cnt_reg + TPC_CNT_STEP;
          dir_down_next = 1'b0;
        end else if (dir_down_reg) begin
          cnt_next = cnt_reg - TPC_CNT_STEP;
        end else begin
          cnt_next = cnt_reg + TPC_CNT_STEP;
        end
      end
    end else if (count_en_in) begin
      // Modulus zero leaves only the full-range wrap
      if (cnt_reg == TPC_CNT_MAX ||
          (mod_reg != TPC_CNT_ZERO && cnt_reg == mod_reg)) begin
        cnt_next = TPC_CNT_ZERO;
        wrap_evt = 1'b1;
      end else begin
        cnt_next = cnt_reg + TPC_CNT_STEP;
      end
    end
  end

  // Direction of the step taken now, for the center PWM match sense
  assign step_up = count_en_in && center_align_select_in && !dir_down_next;

  // Counter register; a counter write restarts from zero counting up
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= TPC_CNT_ZERO;
      dir_down_reg <= 1'b0;
    end else if (main_counter_wr_in) begin
      cnt_reg <= TPC_CNT_ZERO;
      dir_down_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // ==========================================================
  // Modulus byte pairing; commit waits for turnaround in center mode
  assign mod_both = (mod_got_high_reg || (modulus_wr_in && modulus_byte_in.high)) &&
                    (mod_got_low_reg || (modulus_wr_in && !modulus_byte_in.high));
  assign mod_commit = mod_pend_reg && (!center_align_select_in || turn_evt);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mod_buf_reg <= TPC_CNT_ZERO;
      mod_got_high_reg <= 1'b0;
      mod_got_low_reg <= 1'b0;
      mod_pend_reg <= 1'b0;
    end else if (timer_control_wr_in) begin
      mod_got_high_reg <= 1'b0;
      mod_got_low_reg <= 1'b0;
      mod_pend_reg <= 1'b0;
    end else begin
      if (modulus_wr_in && modulus_byte_in.high) begin
        mod_buf_reg[15:8] <= modulus_byte_in.data;
      end
      if (modulus_wr_in && !modulus_byte_in.high) begin
        mod_buf_reg[7:0] <= modulus_byte_in.data;
      end
      if (mod_both) begin
        mod_got_high_reg <= 1'b0;
        mod_got_low_reg <= 1'b0;
        mod_pend_reg <= 1'b1;
      end else begin
        mod_got_high_reg <= mod_got_high_reg || (modulus_wr_in && modulus_byte_in.high);
        mod_got_low_reg <= mod_got_low_reg || (modulus_wr_in && !modulus_byte_in.high);
        if (mod_commit) begin
          mod_pend_reg <= 1'b0;
        end
      end
    end
  end

  // Active modulus
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mod_reg <= TPC_CNT_ZERO;
    end else if (mod_commit && !timer_control_wr_in) begin
      mod_reg <= mod_buf_reg;
    end
  end

  // ==========================================================
  // Overflow flag and its level request
  tpc_flag u_overflow_flag (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .set_in(wrap_evt || turn_evt),
    .rd_in(overflow_flag_rd_in),
    .clr_in(overflow_flag_clr_in),
    .flag_out(overflow_flag_out)
  );

  assign overflow_irq_out = overflow_flag_out && overflow_irq_enable_in;

  // ==========================================================
  // Pin synchronisers; only the second and third stages feed edge logic
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= ch_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ==========================================================
  // Per-channel decode, events and commit conditions
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      is_capture[i] = !center_align_select_in &&
                      channel_control_in[i].mode == TPC_MODE_CAPTURE;
      is_compare[i] = !center_align_select_in &&
                      channel_control_in[i].mode == TPC_MODE_COMPARE;
      is_epwm[i] = !center_align_select_in && channel_control_in[i].mode == TPC_MODE_EPWM;
      // Edge select: rising, falling or either
      unique case (channel_control_in[i].edge_level)
        TPC_EDGE_RISE: cap_evt[i] = pin_sync_reg[i] && !pin_prev_reg[i];
        TPC_EDGE_FALL: cap_evt[i] = !pin_sync_reg[i] && pin_prev_reg[i];
        TPC_EDGE_ANY: cap_evt[i] = pin_sync_reg[i] != pin_prev_reg[i];
        TPC_EDGE_OFF: cap_evt[i] = 1'b0;
      endcase
      cap_evt[i] = cap_evt[i] && is_capture[i];
      // Match is taken on the step into the channel value
      match_evt[i] = count_en_in && !is_capture[i] && !main_counter_wr_in &&
                     cnt_next == val_reg[i];
      flag_set[i] = cap_evt[i] || match_evt[i];
      both_bytes[i] = (got_high_reg[i] ||
                       (channel_value_wr_in[i] && channel_value_byte_in.high)) &&
                      (got_low_reg[i] ||
                       (channel_value_wr_in[i] && !channel_value_byte_in.high));
      // Compares commit at once, PWM waits for its period boundary
      commit[i] = pend_reg[i] && !channel_control_wr_in[i] &&
                  (is_capture[i] || is_compare[i] ||
                   (is_epwm[i] && cnt_reg == TPC_CNT_ZERO) ||
                   (center_align_select_in && turn_evt));
    end
  end

  // ==========================================================
  // Value write buffer and byte pairing
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wbuf_reg <= '0;
      got_high_reg <= '0;
      got_low_reg <= '0;
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (channel_control_wr_in[i]) begin
          got_high_reg[i] <= 1'b0;
          got_low_reg[i] <= 1'b0;
          pend_reg[i] <= 1'b0;
        end else begin
          if (channel_value_wr_in[i] && channel_value_byte_in.high) begin
            wbuf_reg[i][15:8] <= channel_value_byte_in.data;
          end
          if (channel_value_wr_in[i] && !channel_value_byte_in.high) begin
            wbuf_reg[i][7:0] <= channel_value_byte_in.data;
          end
          if (both_bytes[i]) begin
            got_high_reg[i] <= 1'b0;
            got_low_reg[i] <= 1'b0;
            pend_reg[i] <= 1'b1;
          end else begin
            got_high_reg[i] <= got_high_reg[i] ||
                               (channel_value_wr_in[i] && channel_value_byte_in.high);
            got_low_reg[i] <= got_low_reg[i] ||
                              (channel_value_wr_in[i] && !channel_value_byte_in.high);
            if (commit[i]) begin
              pend_reg[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Active channel value: capture loads the count, commit the buffer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      val_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cap_evt[i]) begin
          val_reg[i] <= cnt_reg;
        end else if (commit[i]) begin
          val_reg[i] <= wbuf_reg[i];
        end
      end
    end
  end

  // ==========================================================
  // Coherent reads in capture mode: first byte freezes both until the other byte
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rlatch_reg <= '0;
      rd_hold_reg <= '0;
      rd_first_high_reg <= '0;
      channel_value_rdata_out <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (channel_control_wr_in[i]) begin
          rd_hold_reg[i] <= 1'b0;
        end else if (channel_value_rd_in[i]) begin
          if (rd_hold_reg[i]) begin
            channel_value_rdata_out[i] <= channel_value_byte_in.high ?
                                          rlatch_reg[i][15:8] : rlatch_reg[i][7:0];
            if (channel_value_byte_in.high != rd_first_high_reg[i]) begin
              rd_hold_reg[i] <= 1'b0;
            end
          end else begin
            channel_value_rdata_out[i] <= channel_value_byte_in.high ?
                                          val_reg[i][15:8] : val_reg[i][7:0];
            // Freezing matters only while captures can move the value
            rlatch_reg[i] <= val_reg[i];
            rd_hold_reg[i] <= is_capture[i];
            rd_first_high_reg[i] <= channel_value_byte_in.high;
          end
        end
      end
    end
  end

  // ==========================================================
  // Pin drive per mode
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch_pin_out <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (center_align_select_in) begin
          // Zero or negative value never leaves the inactive level
          if (val_reg[i] == TPC_CNT_ZERO || val_reg[i][TPC_SIGN_BIT]) begin
            ch_pin_out[i] <= channel_control_in[i].edge_level[TPC_POL_BIT];
          end else if (val_reg[i] > mod_reg) begin
            // No compare ever comes above the modulus, so hold the active level
            ch_pin_out[i] <= !channel_control_in[i].edge_level[TPC_POL_BIT];
          end else if (match_evt[i] && step_up) begin
            ch_pin_out[i] <= channel_control_in[i].edge_level[TPC_POL_BIT];
          end else if (match_evt[i]) begin
            ch_pin_out[i] <= !channel_control_in[i].edge_level[TPC_POL_BIT];
          end
        end else if (is_epwm[i]) begin
          // Match wins over wrap so a zero value gives no pulse
          if (match_evt[i]) begin
            ch_pin_out[i] <= channel_control_in[i].edge_level[TPC_POL_BIT];
          end else if (wrap_evt) begin
            ch_pin_out[i] <= !channel_control_in[i].edge_level[TPC_POL_BIT];
          end
        end else if (is_compare[i] && match_evt[i]) begin
          unique case (channel_control_in[i].edge_level)
            TPC_ACT_TOGGLE: ch_pin_out[i] <= !ch_pin_out[i];
            TPC_ACT_CLEAR: ch_pin_out[i] <= 1'b0;
            TPC_ACT_SET: ch_pin_out[i] <= 1'b1;
            TPC_ACT_NONE: ch_pin_out[i] <= ch_pin_out[i];
          endcase
        end
      end
    end
  end

  // Drive enable, low while the channel owns the pin
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch_pin_oe_n_out <= '1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ch_pin_oe_n_out[i] <= !(center_align_select_in || is_epwm[i] ||
                                (is_compare[i] &&
                                 channel_control_in[i].edge_level != TPC_ACT_NONE));
      end
    end
  end

  // ==========================================================
  // Channel flags and level requests
  for (genvar g = 0; g < NCH; g++) begin : g_ch_flag
    tpc_flag u_channel_flag (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .set_in(flag_set[g]),
      .rd_in(channel_flag_rd_in[g]),
      .clr_in(channel_flag_clr_in[g]),
      .flag_out(channel_flag_out[g])
    );
    assign channel_irq_out[g] = channel_flag_out[g] &&
                                channel_control_in[g].irq_enable;
  end

endmodule
`default_nettype wire

// file: verif/tpc_pin_model.sv
// Model of the circuit wired to the channel pins
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
  input wire logic [1:0] lvl_in,
  input wire logic [1:0] oe_n_in,
  input wire logic [1:0] pin_out_in,
  output logic [1:0] wire_out
);
  // Far side drives only a released pin; a driven pin reads back
  assign wire_out = (oe_n_in & lvl_in) | (~oe_n_in & pin_out_in);
endmodule
`default_nettype wire

// file: verif/tpc_timer_assertions.sv
// Assertion checker for the timer channel block
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_chk import tpc_pkg::*; #(
  parameter int NCH = 2
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic count_en_in,
  input wire logic center_align_select_in,
  input wire logic overflow_irq_enable_in,
  input wire logic main_counter_wr_in,
  input wire logic [15:0] main_counter_out,
  input wire logic [15:0] modulus_out,
  input wire logic overflow_flag_clr_in,
  input wire logic overflow_flag_out,
  input wire logic overflow_irq_out,
  input wire tpc_pkg::tpc_ch_cfg_t [NCH-1:0] channel_control_in,
  input wire logic [NCH-1:0] channel_control_wr_in,
  input wire logic [NCH-1:0] channel_flag_clr_in,
  input wire logic [NCH-1:0] channel_flag_out,
  input wire logic [NCH-1:0] channel_irq_out,
  input wire logic [NCH-1:0] ch_pin_in
);
  // ==========================================
  // Helpers
  logic [15:0] term;
  logic stp;
  logic cap_up;
  logic ctr;
  // Zero modulus means the full 16-bit range
  assign term = (modulus_out == 16'h0000) ? 16'hFFFF : modulus_out;
  assign stp = count_en_in && !main_counter_wr_in;
  assign ctr = center_align_select_in;
  // Channel 0 armed for rising capture, nothing disturbing it
  assign cap_up = !ctr && !channel_control_wr_in[0] && !channel_flag_clr_in[0]
    && channel_control_in[0].mode == TPC_MODE_CAPTURE && channel_control_in[0].edge_level[0];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_cap_edge;
    cap_up [*3] ##0 $rose(ch_pin_in[0]);
  endsequence
  sequence s_cap_hold;
    cap_up [*5];
  endsequence
  // ==========================================
  // Properties
  a_ovf_irq_level: assert property (
    overflow_irq_out == (overflow_flag_out && overflow_irq_enable_in))
    else $error("overflow request wrong");
  a_ch_irq_level: assert property (
    channel_irq_out[0] == (channel_flag_out[0] && channel_control_in[0].irq_enable))
    else $error("channel request wrong");
  a_ovf_clear_seq: assert property (
    $fell(overflow_flag_out) |-> $past(overflow_flag_clr_in))
    else $error("overflow flag fell without clear");
  a_chf_clear_seq: assert property (
    $fell(channel_flag_out[0]) |-> $past(channel_flag_clr_in[0]))
    else $error("channel flag fell without clear");
  a_up_count_step: assert property (
    !ctr && stp && main_counter_out != term |=>
    main_counter_out == $past(main_counter_out) + 16'h0001)
    else $error("counter step wrong");
  a_up_wrap_flag: assert property (
    !ctr && stp && main_counter_out == term |=> main_counter_out == 16'h0000 && overflow_flag_out)
    else $error("wrap or overflow wrong");
  a_center_turn_flag: assert property (
    ctr && stp && modulus_out != 16'h0000 && main_counter_out == modulus_out |=>
    main_counter_out == $past(main_counter_out) - 16'h0001 && overflow_flag_out)
    else $error("turnaround wrong");
  a_cap_sets_flag: assert property (
    s_cap_edge ##1 s_cap_hold |-> channel_flag_out[0])
    else $error("capture flag missing");
endmodule
bind tpc_timer tpc_timer_chk #(.NCH(NCH)) u_chk (.mclk_in, .arst_n_in, .count_en_in,
  .center_align_select_in, .overflow_irq_enable_in, .main_counter_wr_in, .main_counter_out,
  .modulus_out, .overflow_flag_clr_in, .overflow_flag_out, .overflow_irq_out,
  .channel_control_in, .channel_control_wr_in, .channel_flag_clr_in, .channel_flag_out,
  .channel_irq_out, .ch_pin_in);
`default_nettype wire

// file: verif/test_tpc_timer.sv
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
`default_nettype none
module test_tpc_timer;
  import tpc_pkg::*;
  logic mclk_in, arst_n_in, ce, tcw, cas, oie, cw, mw, ofr, ofc, of, oi;
  logic [1:0] ccw, vw, vr, fr, fc, lvl, pin_in, pin_out, oe_n, cf, ci;
  logic [15:0] cnt, mods, v;
  logic [1:0][7:0] rd;
  logic [31:0] rs;
  tpc_byte_t mb, vb;
  tpc_ch_cfg_t [1:0] cc;
  int fail_count, compares, mcnt, mmod, mup;
  logic [1:0] ec [3] = '{TPC_EDGE_RISE, TPC_EDGE_FALL, TPC_EDGE_ANY};
  logic [1:0] ac [3] = '{TPC_ACT_SET, TPC_ACT_CLEAR, TPC_ACT_TOGGLE};
  logic [15:0] cv [4] = '{16'h0000, 16'h0002, 16'h0006, 16'h8002};
  int ev [3] = '{0, 2, 6};
  int eh [3] = '{0, 4, 12};
  int ch [4] = '{0, 8, 20, 0};
  tpc_timer #(.NCH(2)) DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .count_en_in(ce),
    .timer_control_wr_in(tcw), .center_align_select_in(cas), .overflow_irq_enable_in(oie),
    .main_counter_wr_in(cw), .modulus_wr_in(mw), .modulus_byte_in(mb),
    .main_counter_out(cnt), .modulus_out(mods), .overflow_flag_rd_in(ofr),
    .overflow_flag_clr_in(ofc), .overflow_flag_out(of), .overflow_irq_out(oi),
    .channel_control_in(cc), .channel_control_wr_in(ccw), .channel_value_wr_in(vw),
    .channel_value_rd_in(vr), .channel_value_byte_in(vb), .channel_value_rdata_out(rd),
    .channel_flag_rd_in(fr), .channel_flag_clr_in(fc), .channel_flag_out(cf),
    .channel_irq_out(ci), .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe_n_out(oe_n));
  tpc_pin_model PM (.lvl_in(lvl), .oe_n_in(oe_n), .pin_out_in(pin_out), .wire_out(pin_in));
  // ==========================================
  // Clock, reference counter and watchdog
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // Counter model, stepped on the same edges as the design
  always @(posedge mclk_in) begin
    if (arst_n_in && cw) begin
      mcnt = 0;
      mup = 1;
    end else if (arst_n_in && ce) begin
      if (!cas) mcnt = (mcnt == (mmod != 0 ? mmod : 65535)) ? 0 : mcnt + 1;
      else if (mup != 0 && mcnt == mmod) begin
        mup = 0;
        mcnt = mcnt - 1;
      end else if (mup == 0 && mcnt == 0) begin
        mup = 1;
        mcnt = 1;
      end else mcnt = (mup != 0) ? mcnt + 1 : mcnt - 1;
    end
  end
  // Counter compared mid-cycle, where it is settled
  always @(negedge mclk_in) if (arst_n_in) check(cnt, mcnt[15:0]);
  // Whole run is about 66k cycles
  initial begin
    #700000;
    fail_count++;
    summarize;
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask
  // Trailing tick keeps two pulses of one signal apart
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask
  task automatic runc(input int n);
    repeat (n) begin
      ce = 1'b1;
      tick;
    end
    ce = 1'b0;
  endtask
  task automatic modw(input logic [15:0] m);
    mb = '{1'b1, m[15:8]};
    pulse(mw);
    mb = '{1'b0, m[7:0]};
    pulse(mw);
    mmod = m;
    check(mods, m);
  endtask
  task automatic bw(input int c, input logic h, input logic [7:0] d);
    vb = '{h, d};
    vw[c] = 1'b1;
    tick;
    vw[c] = 1'b0;
    tick;
  endtask
  task automatic cfg(input int c, input tpc_ch_cfg_t k);
    cc[c] = k;
    ccw[c] = 1'b1;
    tick;
    ccw[c] = 1'b0;
  endtask
  task automatic rdv(input int c, input logic h, input logic [7:0] e);
    vb.high = h;
    vr[c] = 1'b1;
    tick;
    vr[c] = 1'b0;
    check(rd[c], e);
    tick;
  endtask
  task automatic fclr(input int c);
    fr[c] = 1'b1;
    tick;
    fr[c] = 1'b0;
    fc[c] = 1'b1;
    tick;
    fc[c] = 1'b0;
    repeat (2) tick;
  endtask
  task automatic ovc(input logic r, input int n, input logic e);
    if (r) pulse(ofr);
    runc(n);
    pulse(ofc);
    check(of, e);
  endtask
  task automatic hi(input int c, input int n, input int e);
    int h;
    h = 0;
    repeat (n) begin
      tick;
      h += pin_out[c];
    end
    check(h, e);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {arst_n_in, ce, tcw, cas, oie, cw, mw, ofr, ofc} = '0;
    {ccw, vw, vr, fr, fc, lvl, mb, vb, cc} = '0;
    {fail_count, compares, mcnt, mmod} = '0;
    mup = 1;
    rs = 32'h5E46;
    repeat (3) @(posedge mclk_in);
    #1;
    arst_n_in = 1'b1;
    check(oe_n, 2'h3);
    modw(16'h0005);
    // Half-written modulus must be dropped by a control write
    mb = '{1'b1, 8'h12};
    pulse(mw);
    pulse(tcw);
    mb = '{1'b0, 8'h07};
    pulse(mw);
    check(mods, 16'h0005);
    pulse(tcw);
    oie = 1'b1;
    repeat (80) begin
      rs = xs(rs);
      ce = rs[0];
      tick;
    end
    ce = 1'b0;
    check(oi, 1'b1);
    ovc(1'b0, 0, 1'b1);
    ovc(1'b1, 6, 1'b1);
    ovc(1'b1, 0, 1'b0);
    modw(16'h0000);
    runc(65536);
    check(of, 1'b1);
    modw(16'h0005);
    for (int i = 0; i < 3; i++) begin
      cfg(0, '{1'b1, TPC_MODE_CAPTURE, ec[i]});
      fclr(0);
      lvl[0] = 1'b1;
      repeat (6) tick;
      check(ci[0], ec[i] != TPC_EDGE_FALL);
      fclr(0);
      lvl[0] = 1'b0;
      repeat (6) tick;
      check(cf[0], ec[i] != TPC_EDGE_RISE);
    end
    // Frozen pair survives a new capture until the other byte is read
    v = mcnt[15:0];
    rdv(0, 1'b1, v[15:8]);
    runc(3);
    lvl[0] = 1'b1;
    repeat (6) tick;
    rdv(0, 1'b0, v[7:0]);
    v = mcnt[15:0];
    rdv(0, 1'b0, v[7:0]);
    cfg(1, '{1'b1, TPC_MODE_COMPARE, TPC_ACT_NONE});
    bw(1, 1'b0, 8'h03);
    bw(1, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cfg(1, '{1'b1, TPC_MODE_COMPARE, ac[i]});
      fclr(1);
      pulse(cw);
      runc(4);
      check(pin_out[1], i != 1);
      check(ci[1], 1'b1);
    end
    // Control write between bytes keeps the old compare value
    bw(1, 1'b0, 8'h09);
    cfg(1, '{1'b0, TPC_MODE_COMPARE, TPC_ACT_TOGGLE});
    bw(1, 1'b1, 8'h00);
    pulse(cw);
    runc(4);
    check(pin_out[1], 1'b0);
    for (int p = 0; p < 2; p++) for (int k = 0; k < 3; k++) begin
      cfg(1, '{1'b0, TPC_MODE_EPWM, {1'b0, p[0]}});
      bw(1, 1'b0, ev[k][7:0]);
      bw(1, 1'b1, 8'h00);
      ce = 1'b1;
      repeat (12) tick;
      hi(1, 12, p != 0 ? 12 - eh[k] : eh[k]);
      ce = 1'b0;
    end
    // Center mode with modulus 5, also with values outside the range software must keep
    cfg(0, '{1'b0, TPC_MODE_CAPTURE, 2'h0});
    cas = 1'b1;
    pulse(cw);
    for (int k = 0; k < 4; k++) begin
      bw(0, 1'b0, cv[k][7:0]);
      bw(0, 1'b1, cv[k][15:8]);
      ce = 1'b1;
      repeat (20) tick;
      hi(0, 20, ch[k]);
      ce = 1'b0;
    end
    summarize;
  end
endmodule
`default_nettype wire
